// ---- rgs_pkg.sv ----
`default_nettype none
package rgs_pkg;
	// Byte addresses of the register bank
	localparam logic [7:0] RGS_ADDR_DISQ = 8'h0b;
	localparam logic [7:0] RGS_ADDR_QUAL = 8'h0c;
	localparam logic [7:0] RGS_ADDR_FREEZE = 8'h0d;
	localparam logic [7:0] RGS_ADDR_RATE_HI = 8'h10;
	localparam logic [7:0] RGS_ADDR_RATE_LO = 8'h11;
	// Reset values
	localparam logic [7:0] RGS_RST_DISQ = 8'haa;
	localparam logic [7:0] RGS_RST_QUAL = 8'h55;
	localparam logic [7:0] RGS_RST_FREEZE = 8'h00;
	localparam logic [15:0] RGS_RST_RATE = 16'h9c40;
	// Freeze register command values
	localparam logic [7:0] RGS_FREEZE_ON = 8'h01;
	localparam logic [7:0] RGS_FREEZE_OFF = 8'h00;
	// Field width and reference count
	localparam int RGS_NREF = 4;
	localparam int RGS_FW = 2;
	// Clock rate and delay figures
	localparam longint RGS_CLK_HZ = 125000000;
	localparam longint RGS_T10_MS = 10;
	localparam longint RGS_T50_MS = 50;
	localparam longint RGS_T2500_MS = 2500;
	localparam int RGS_CNT_W = 32;
	// Longest delays round down to whole cycles
	localparam longint RGS_CYC_10 = RGS_CLK_HZ * RGS_T10_MS / 1000;
	localparam longint RGS_CYC_50 = RGS_CLK_HZ * RGS_T50_MS / 1000;
	localparam longint RGS_CYC_2500 = RGS_CLK_HZ * RGS_T2500_MS / 1000;
	// Minimum delay: one cycle
	localparam longint RGS_CYC_MIN = 1;
	// Guard timer states
	typedef enum logic [1:0] {
		RGS_QUALIFIED = 2'b00,
		RGS_DISQ_WAIT = 2'b01,
		RGS_FAILED = 2'b10,
		RGS_QUAL_WAIT = 2'b11
	} rgs_state_e;
endpackage : rgs_pkg
`default_nettype wire

// ---- rgs_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
// One reference's guard soak timer
module rgs_guard #(
	parameter logic [31:0] CYC_MIN = 32'h1,
	parameter logic [31:0] CYC_10 = 32'h1,
	parameter logic [31:0] CYC_50 = 32'h1,
	parameter logic [31:0] CYC_2500 = 32'h1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cfm_i,
	input wire logic scm_i,
	input wire logic [1:0] disq_code_i,
	input wire logic [1:0] qual_code_i,
	output logic qualified_o
);
	rgs_pkg::rgs_state_e state_q;
	logic [31:0] cnt_q;
	logic [31:0] disq_len;
	logic [31:0] qual_len;
	logic fault;

	assign fault = cfm_i | scm_i;

	always_comb
	begin
		case (disq_code_i)
			2'b00: disq_len = CYC_MIN;
			2'b01: disq_len = CYC_10;
			2'b10: disq_len = CYC_50;
			default: disq_len = CYC_2500;
		endcase
	end

	always_comb
	begin
		qual_len = disq_len * ({30'h0, qual_code_i} + 32'h1) * 32'h2;
	end

	// Timer state machine
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= rgs_pkg::RGS_QUALIFIED;
			cnt_q <= 32'h0;
			qualified_o <= 1'b1;
		end
		else if (ce_i)
		begin
			case (state_q)
				rgs_pkg::RGS_QUALIFIED:
				begin
					cnt_q <= 32'h0;
					if (fault)
						state_q <= rgs_pkg::RGS_DISQ_WAIT;
				end
				rgs_pkg::RGS_DISQ_WAIT:
				begin
					// Delay keeps running even if fault drops: soak is committed
					if (cnt_q + 32'h1 >= disq_len)
					begin
						state_q <= rgs_pkg::RGS_FAILED;
						qualified_o <= 1'b0;
						cnt_q <= 32'h0;
					end
					else
						cnt_q <= cnt_q + 32'h1;
				end
				rgs_pkg::RGS_FAILED:
				begin
					cnt_q <= 32'h0;
					if (!fault)
						state_q <= rgs_pkg::RGS_QUAL_WAIT;
				end
				rgs_pkg::RGS_QUAL_WAIT:
				begin
					if (fault)
					begin
						state_q <= rgs_pkg::RGS_FAILED;
						cnt_q <= 32'h0;
					end
					else if (cnt_q + 32'h1 >= qual_len)
					begin
						state_q <= rgs_pkg::RGS_QUALIFIED;
						qualified_o <= 1'b1;
						cnt_q <= 32'h0;
					end
					else
						cnt_q <= cnt_q + 32'h1;
				end
				default:
					state_q <= rgs_pkg::RGS_QUALIFIED;
			endcase
		end
	end

	requal_clean_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && state_q == rgs_pkg::RGS_QUAL_WAIT && fault) |=>
		state_q == rgs_pkg::RGS_FAILED && !qualified_o)
		else $error("qualify delay not abandoned on fault");
endmodule : rgs_guard
`default_nettype wire

// ---- rgs_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Disqualify code picks min, 10ms, 50ms, 2.5s
// - Either fault starts disqualify, then disqualify
// - Qualify delay is 2,4,6,8 times disqualify
// - Both faults clear, qualify delay, requalify
// - Four 2-bit fields per delay register
// - Qualify register resets to 0x55
// - Writing 0x01 freezes sticky status updates
// - Writing 0x00 resumes updates; reset 0x00
// - Base rate is 16-bit hertz value
// - Base rate resets to 0x9c40
// - Wide registers big-endian, MSB lower address
module rgs_top (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	output logic [7:0] RDATA_O,
	input wire logic [3:0] CFM_FAULT_I,
	input wire logic [3:0] SCM_FAULT_I,
	output logic [3:0] REF_QUALIFIED_O,
	output logic [3:0] STICKY_FAIL_O,
	output logic STATUS_FROZEN_O,
	output logic [15:0] BASE_RATE_O,
	output logic [7:0] DISQ_SEL_O,
	output logic [7:0] QUAL_SEL_O
);
	logic [7:0] freeze_q; // Full byte kept so it reads back as written
	logic [3:0] qual_w; // Per-reference guard outputs
	logic [3:0] sticky_q; // Sticky fail latch

	// delay selects, two bits per reference
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			DISQ_SEL_O <= rgs_pkg::RGS_RST_DISQ;
			QUAL_SEL_O <= rgs_pkg::RGS_RST_QUAL;
		end
		else if (CE_I && WR_I)
		begin
			if (ADDR_I == rgs_pkg::RGS_ADDR_DISQ)
				DISQ_SEL_O <= WDATA_I;
			if (ADDR_I == rgs_pkg::RGS_ADDR_QUAL)
				QUAL_SEL_O <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			freeze_q <= rgs_pkg::RGS_RST_FREEZE;
		else if (CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_FREEZE)
			freeze_q <= WDATA_I;
	end

	// Frozen only for the documented lock value; other values leave updates on
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			STATUS_FROZEN_O <= 1'b0;
		else if (CE_I)
			STATUS_FROZEN_O <= (freeze_q == rgs_pkg::RGS_FREEZE_ON);
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			BASE_RATE_O <= rgs_pkg::RGS_RST_RATE;
		else if (CE_I && WR_I)
		begin
			if (ADDR_I == rgs_pkg::RGS_ADDR_RATE_HI)
				BASE_RATE_O[15:8] <= WDATA_I;
			if (ADDR_I == rgs_pkg::RGS_ADDR_RATE_LO)
				BASE_RATE_O[7:0] <= WDATA_I;
		end
	end

	// Per-reference guard timers
	genvar g;
	generate
		for (g = 0; g < rgs_pkg::RGS_NREF; g++)
		begin : gen_ref
			rgs_guard #(
				.CYC_MIN(32'(rgs_pkg::RGS_CYC_MIN)),
				.CYC_10(32'(rgs_pkg::RGS_CYC_10)),
				.CYC_50(32'(rgs_pkg::RGS_CYC_50)),
				.CYC_2500(32'(rgs_pkg::RGS_CYC_2500))
			) u_guard (
				.clk_i(CLK_I),
				.rst_i(RST_I),
				.ce_i(CE_I),
				.cfm_i(CFM_FAULT_I[g]),
				.scm_i(SCM_FAULT_I[g]),
				.disq_code_i(DISQ_SEL_O[2*g+1:2*g]),
				.qual_code_i(QUAL_SEL_O[2*g+1:2*g]),
				.qualified_o(qual_w[g])
			);
		end
	endgenerate

	// Qualified state registered once more for a flop-driven output
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			REF_QUALIFIED_O <= 4'hf;
		else if (CE_I)
			REF_QUALIFIED_O <= qual_w;
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			sticky_q <= 4'h0;
		else if (CE_I && !STATUS_FROZEN_O)
			sticky_q <= sticky_q | ~qual_w;
	end

	// Visible copy; it has no read address and only reset clears it
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			STICKY_FAIL_O <= 4'h0;
		else if (CE_I)
			STICKY_FAIL_O <= sticky_q;
	end

	// Read mux, unmapped addresses read zero
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			RDATA_O <= 8'h00;
		else if (CE_I && RD_I)
		begin
			case (ADDR_I)
				rgs_pkg::RGS_ADDR_DISQ: RDATA_O <= DISQ_SEL_O;
				rgs_pkg::RGS_ADDR_QUAL: RDATA_O <= QUAL_SEL_O;
				rgs_pkg::RGS_ADDR_FREEZE: RDATA_O <= freeze_q;
				rgs_pkg::RGS_ADDR_RATE_HI: RDATA_O <= BASE_RATE_O[15:8];
				rgs_pkg::RGS_ADDR_RATE_LO: RDATA_O <= BASE_RATE_O[7:0];
				default: RDATA_O <= 8'h00;
			endcase
		end
	end

	sticky_frozen_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		STATUS_FROZEN_O |=> $stable(sticky_q))
		else $error("sticky status changed while frozen");

	lock_write_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_FREEZE &&
		WDATA_I == rgs_pkg::RGS_FREEZE_ON) ##1 CE_I
		|=> STATUS_FROZEN_O)
		else $error("lock value did not freeze status");

	unlock_write_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_FREEZE &&
		WDATA_I == rgs_pkg::RGS_FREEZE_OFF) ##1 CE_I
		|=> !STATUS_FROZEN_O)
		else $error("unlock value did not resume updates");

	// lock register reads back as written
	freeze_read_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && RD_I && ADDR_I == rgs_pkg::RGS_ADDR_FREEZE)
		|=> RDATA_O == $past(freeze_q))
		else $error("lock register read back wrong");

	// high byte lands in upper half
	rate_hi_byte_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_RATE_HI)
		|=> BASE_RATE_O[15:8] == $past(WDATA_I)
		&& BASE_RATE_O[7:0] == $past(BASE_RATE_O[7:0]))
		else $error("big-endian high byte misplaced");

	// low byte lands in lower half
	rate_lo_byte_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_RATE_LO)
		|=> BASE_RATE_O[7:0] == $past(WDATA_I))
		else $error("base rate low byte misplaced");

	disq_store_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_DISQ)
		|=> DISQ_SEL_O == $past(WDATA_I))
		else $error("disqualify select not stored");

	qual_store_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && WR_I && ADDR_I == rgs_pkg::RGS_ADDR_QUAL)
		|=> QUAL_SEL_O == $past(WDATA_I))
		else $error("qualify select not stored");

	disq_reset_a: assert property (
		@(posedge CLK_I)
		$past(RST_I) |-> DISQ_SEL_O == rgs_pkg::RGS_RST_DISQ &&
		QUAL_SEL_O == rgs_pkg::RGS_RST_QUAL)
		else $error("delay select reset value wrong");

	rate_reset_a: assert property (
		@(posedge CLK_I)
		$past(RST_I) |-> BASE_RATE_O == rgs_pkg::RGS_RST_RATE &&
		!STATUS_FROZEN_O)
		else $error("base rate reset value wrong");

	min_disq_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(CE_I && DISQ_SEL_O[1:0] == 2'b00 && gen_ref[0].u_guard.state_q ==
		rgs_pkg::RGS_QUALIFIED && (CFM_FAULT_I[0] | SCM_FAULT_I[0]))
		##1 CE_I [*2] |=> !qual_w[0])
		else $error("minimum disqualify delay not honoured");

	// Clock enable low holds selects, base rate, read data, lock byte, qualified and sticky outputs
	ce_hold_a: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		!CE_I |=> $stable(DISQ_SEL_O) && $stable(QUAL_SEL_O) &&
		$stable(BASE_RATE_O) && $stable(RDATA_O) &&
		$stable(REF_QUALIFIED_O) && $stable(STICKY_FAIL_O) &&
		$stable(freeze_q))
		else $error("state moved with clock enable low");
endmodule : rgs_top
`default_nettype wire

// ---- ref_guard_soak_qualifier_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ref_guard_soak_qualifier_tb;
	// Bench side of the register port and monitors
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic CE_I = 1'b1;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic [7:0] WDATA_I = 8'h00;
	logic [3:0] CFM_FAULT_I = 4'h0;
	logic [3:0] SCM_FAULT_I = 4'h0;
	logic [7:0] RDATA_O, DISQ_SEL_O, QUAL_SEL_O;
	logic [3:0] REF_QUALIFIED_O, STICKY_FAIL_O;
	logic STATUS_FROZEN_O;
	logic [15:0] BASE_RATE_O;
	int mismatches = 0;
	int tests_run = 0;
	// Model image of the bank, byte addressed
	logic [7:0] m [0:255];
	logic [7:0] al [6] = '{8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h20};
	int t [4];
	int n;
	// Supported base rates only; host keeps to this set
	logic [15:0] rates [9] = '{16'h03e8, 16'h07d0, 16'h1388, 16'h186a,
		16'h1f40, 16'h2710, 16'h30d4, 16'h61a8, 16'h9c40};
	logic [15:0] rate;
	logic [7:0] keep;
	always #4 CLK_I = ~CLK_I;
	rgs_top dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .WR_I(WR_I),
		.RD_I(RD_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
		.CFM_FAULT_I(CFM_FAULT_I), .SCM_FAULT_I(SCM_FAULT_I),
		.REF_QUALIFIED_O(REF_QUALIFIED_O), .STICKY_FAIL_O(STICKY_FAIL_O),
		.STATUS_FROZEN_O(STATUS_FROZEN_O), .BASE_RATE_O(BASE_RATE_O),
		.DISQ_SEL_O(DISQ_SEL_O), .QUAL_SEL_O(QUAL_SEL_O));
	// Verdict and end of run
	task automatic results;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// Value compare, four-state
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic mapped(input logic [7:0] a);
		return a inside {8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11};
	endfunction : mapped
	task automatic tick(input int k);
		repeat (k) @(posedge CLK_I);
	endtask : tick
	// Extra edge after the strobe drops keeps drivers single per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		WR_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		if (mapped(a))
			m[a] = d;
		@(posedge CLK_I);
	endtask : wr
	// Read data is sampled one edge after the taking edge
	task automatic rd(input logic [7:0] a);
		RD_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		@(posedge CLK_I);
		chk(RDATA_O, mapped(a) ? m[a] : 8'h00);
	endtask : rd
	// Bounded wait on one qualified bit, counts edges
	task automatic wq(input int r, input logic lv, output int c);
		c = 0;
		while (REF_QUALIFIED_O[r] !== lv)
		begin
			@(posedge CLK_I);
			c++;
			if (c > 300)
			begin
				mismatches++;
				$display("wrong value at %0t: wait ran out", $time);
				results;
			end
		end
	endtask : wq
	initial
	begin
		void'($urandom(32'h53e2));
		m[8'h0b] = 8'haa;
		m[8'h0c] = 8'h55;
		m[8'h0d] = 8'h00;
		m[8'h10] = 8'h9c;
		m[8'h11] = 8'h40;
		tick(2);
		RST_I <= 1'b0;
		tick(1);
		// Reset image, unmapped read included
		foreach (al[i]) rd(al[i]);
		chk({DISQ_SEL_O, QUAL_SEL_O}, 16'haa55);
		chk(BASE_RATE_O, 16'h9c40);
		// Random traffic, lock register left alone
		repeat (4)
		begin
			foreach (al[i]) if (al[i] inside {8'h0b, 8'h0c, 8'h20}) wr(al[i], 8'($urandom));
			// rate drawn from the supported set
			rate = rates[$urandom % 9];
			// high byte at the lower address first
			wr(8'h10, rate[15:8]);
			wr(8'h11, rate[7:0]);
			foreach (al[i]) rd(al[i]);
			chk(BASE_RATE_O, rate);
		end
		// High byte lands alone, then low byte
		wr(8'h10, 8'h03);
		chk(BASE_RATE_O, {8'h03, m[8'h11]});
		wr(8'h11, 8'he8);
		chk(BASE_RATE_O, 16'h03e8);
		// Freeze, then fault ref 3 with minimum delays
		wr(8'h0d, 8'h01);
		tick(2);
		chk(STATUS_FROZEN_O, 16'h1);
		wr(8'h0b, 8'h00);
		wr(8'h0c, 8'h00);
		CFM_FAULT_I <= 4'h8;
		wq(3, 1'b0, n);
		tick(3);
		chk(STICKY_FAIL_O, 16'h0);
		wr(8'h0d, 8'h00);
		tick(3);
		chk(STATUS_FROZEN_O, 16'h0);
		chk(STICKY_FAIL_O, 16'h8);
		wr(8'h0d, 8'h02);
		tick(2);
		rd(8'h0d);
		chk(STATUS_FROZEN_O, 16'h0);
		CFM_FAULT_I <= 4'h0;
		wq(3, 1'b1, n);
		// One fault still up holds the reference off
		CFM_FAULT_I <= 4'h1;
		SCM_FAULT_I <= 4'h1;
		wq(0, 1'b0, n);
		CFM_FAULT_I <= 4'h0;
		tick(30);
		chk(REF_QUALIFIED_O, 16'he);
		SCM_FAULT_I <= 4'h0;
		wq(0, 1'b1, n);
		// Each qualify code on its own field
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h0c, {4{2'(c)}});
			if (c % 2)
				SCM_FAULT_I <= 4'(1 << c);
			else
				CFM_FAULT_I <= 4'(1 << c);
			wq(c, 1'b0, n);
			chk(REF_QUALIFIED_O, 16'(~(4'h1 << c) & 4'hf));
			CFM_FAULT_I <= 4'h0;
			SCM_FAULT_I <= 4'h0;
			wq(c, 1'b1, t[c]);
			chk(16'(t[c] - t[0]), 16'(2 * c));
		end
		// Fault inside the qualify wait restarts it
		CFM_FAULT_I <= 4'h4;
		wq(2, 1'b0, n);
		CFM_FAULT_I <= 4'h0;
		tick(3);
		CFM_FAULT_I <= 4'h4;
		tick(1);
		CFM_FAULT_I <= 4'h0;
		wq(2, 1'b1, n);
		chk(16'(n), 16'(t[3]));
		// Clock enable low: write and fault both ignored
		keep = m[8'h0b];
		CE_I <= 1'b0;
		SCM_FAULT_I <= 4'h1;
		wr(8'h0b, ~keep);
		m[8'h0b] = keep;
		tick(8);
		chk(REF_QUALIFIED_O, 16'hf);
		CE_I <= 1'b1;
		SCM_FAULT_I <= 4'h0;
		rd(8'h0b);
		// Longer code must not act like the minimum
		wr(8'h0b, 8'h04);
		SCM_FAULT_I <= 4'h2;
		tick(500);
		chk(REF_QUALIFIED_O, 16'hf);
		// Reset in mid-run restores defaults
		RST_I <= 1'b1;
		SCM_FAULT_I <= 4'h0;
		tick(2);
		RST_I <= 1'b0;
		tick(1);
		chk({DISQ_SEL_O, QUAL_SEL_O}, 16'haa55);
		chk({REF_QUALIFIED_O, STICKY_FAIL_O}, 16'hf0);
		chk(BASE_RATE_O, 16'h9c40);
		results;
	end
endmodule : ref_guard_soak_qualifier_tb
`default_nettype wire
